//--- hdl/mpc_consts.svh
// Constants for the multipurpose command decoder and its controller.
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// Operand encodings.
`define MPC_OP_RD_BUF     7'h41
`define MPC_OP_PATTERN    7'h43
`define MPC_OP_RSV_A      7'h45
`define MPC_OP_WR_BUF     7'h47
`define MPC_OP_RSV_B      7'h49
`define MPC_OP_OSC_START  7'h4B
`define MPC_OP_OSC_STOP   7'h4D
`define MPC_OP_CAL_START  7'h4F
`define MPC_OP_CAL_LATCH  7'h51

// Bit positions and first-edge codes on the command/address lines.
`define MPC_OP_TOP_BIT    6
`define MPC_CA_TOP_BIT    5
`define MPC_CODE_TOP_BIT  4
`define MPC_FIRST_LOW     5'h00
`define MPC_CAS2_LOW      5'h12
`define MPC_CA_ZERO       6'h00

// Buffer read and buffer write training bursts are sixteen beats.
`define MPC_TRAIN_BL      5'h10
`define MPC_BL_RESET      5'h00

`endif

//--- hdl/mpc_pkg.sv
// Types shared by both ends of the multipurpose command link.
package mpc_pkg;

   typedef enum logic [3:0] {
      MPC_FN_NOP,
      MPC_FN_RD_BUF,
      MPC_FN_PATTERN,
      MPC_FN_WR_BUF,
      MPC_FN_OSC_START,
      MPC_FN_OSC_STOP,
      MPC_FN_CAL_START,
      MPC_FN_CAL_LATCH,
      MPC_FN_RESERVED,
      MPC_FN_UNDEF
   } mpc_fn_e;

   typedef logic [6:0] mpc_operand_t;
   typedef logic [5:0] mpc_ca_t;

endpackage

//--- hdl/mpc_if.sv
// Command/address link between memory controller and DRAM decoder.
`timescale 1ns/1ps
interface mpc_if;
   logic             cke;
   logic             cs;
   mpc_pkg::mpc_ca_t ca;

   modport ctrl (output cke, output cs, output ca);
   modport dram (input cke, input cs, input ca);
endinterface

//--- hdl/mpc_operand_decode.sv
// Operand field decoder: seven-bit operand to training function.
`timescale 1ns/1ps
module mpc_operand_decode (
   // Operand in
   input  wire mpc_pkg::mpc_operand_t operand_field,
   // Decoded function out
   output mpc_pkg::mpc_fn_e           fn,
   output logic                       needs_cas2
);
   import mpc_pkg::*;
   `include "mpc_consts.svh"

   always_comb begin
      fn = MPC_FN_UNDEF;
      if (!operand_field[`MPC_OP_TOP_BIT]) begin
         fn = MPC_FN_NOP; // R4
      end else begin
         unique case (operand_field)
            `MPC_OP_RD_BUF:    fn = MPC_FN_RD_BUF; // R9
            `MPC_OP_PATTERN:   fn = MPC_FN_PATTERN; // R9
            `MPC_OP_WR_BUF:    fn = MPC_FN_WR_BUF; // R9
            `MPC_OP_OSC_START: fn = MPC_FN_OSC_START; // R10
            `MPC_OP_OSC_STOP:  fn = MPC_FN_OSC_STOP; // R10
            `MPC_OP_CAL_START: fn = MPC_FN_CAL_START; // R11
            `MPC_OP_CAL_LATCH: fn = MPC_FN_CAL_LATCH; // R11
            `MPC_OP_RSV_A,
            `MPC_OP_RSV_B:     fn = MPC_FN_RESERVED;
            default:           fn = MPC_FN_UNDEF;
         endcase
      end
   end

   // Only the three data-moving functions wait for a CAS-2 command.
   assign needs_cas2 = (fn == MPC_FN_RD_BUF) || (fn == MPC_FN_PATTERN) || // R8
                       (fn == MPC_FN_WR_BUF);
endmodule

//--- hdl/mpc_device.sv
// DRAM-side decoder of the multipurpose command on the command/address bus.
`timescale 1ns/1ps

// Behaviour
// R1 - Controller drives CS and CA per encoding
// R2 - Operand split over two edges, bit 6 first
// R3 - Operand bit 6 decoded on first edge
// R4 - Bit 6 low is NOP, high selects training
// R5 - Data training is followed directly by CAS-2
// R6 - Latency counted from CAS-2 second edge
// R7 - CAS-2 operands after training are low
// R8 - NOP, oscillator, calibration need no CAS-2
// R9 - Decode buffer read, pattern, buffer write
// R10 - Decode oscillator start and stop
// R11 - Decode calibration start and latch
// R12 - Reserved codes never issued by controller
// R13 - Training bursts are sixteen beats always; pattern reads leave train_bl_q unchanged
// R14 - CKE held high across both edges
module mpc_device #(
   parameter int CA_W = 6
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Link from the controller
   mpc_if.dram                    link,
   // Decoded functions, one-cycle pulses
   output logic                   nop_q,
   output logic                   train_rd_q,
   output logic                   pattern_rd_q,
   output logic                   train_wr_q,
   output logic                   cal_start_q,
   output logic                   cal_latch_q,
   // Training burst length and oscillator state
   output logic [4:0]             train_bl_q,
   output logic                   osc_run_q,
   // Faults, one-cycle pulses
   output logic                   reserved_code_q,
   output logic                   undef_code_q,
   output logic                   seq_error_q
);
   import mpc_pkg::*;
   `include "mpc_consts.svh"

   // Other bus widths are refused while the design is built, not at run time.
   if (CA_W != `MPC_CA_TOP_BIT + 1) begin : g_bad_width
      $error("mpc_device serves only a six-line command/address bus");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MPC_ST_IDLE,
      MPC_ST_NOP2,
      MPC_ST_TRAIN2,
      MPC_ST_CAS1,
      MPC_ST_CAS2
   } mpc_state_e;

   mpc_state_e   state_q;
   mpc_state_e   state_d;
   mpc_operand_t operand_d;
   mpc_fn_e      fn;
   logic         needs_cas2;
   mpc_fn_e      pend_fn_q;
   logic         first_edge;
   logic         cas2_first;
   logic         err_d;

   // A command's first edge: chip select high with clock enable high.
   assign first_edge = link.cs && link.cke; // R14
   assign cas2_first = first_edge && (link.ca[`MPC_CODE_TOP_BIT:0] == `MPC_CAS2_LOW) &&
                       !link.ca[`MPC_CA_TOP_BIT]; // R7

   // The full operand is assembled at the second edge from the line
   // captured at the first; the top bit was already acted on.
   logic op_top_q;
   assign operand_d = {op_top_q, link.ca}; // R2

   mpc_operand_decode u_decode (
      .operand_field (operand_d),
      .fn            (fn),
      .needs_cas2    (needs_cas2)
   );

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      err_d   = 1'b0;
      unique case (state_q)
         MPC_ST_IDLE: begin
            if (first_edge && (link.ca[`MPC_CODE_TOP_BIT:0] == `MPC_FIRST_LOW)) begin
               // Bit 6 picks the path before the rest arrives.
               if (link.ca[`MPC_CA_TOP_BIT]) begin // R3
                  state_d = MPC_ST_TRAIN2;
               end else begin
                  state_d = MPC_ST_NOP2; // R4
               end
            end
         end
         MPC_ST_NOP2: begin
            state_d = MPC_ST_IDLE;
            if (link.cs || !link.cke) begin
               err_d = 1'b1;
            end
         end
         MPC_ST_TRAIN2: begin
            if (link.cs || !link.cke) begin
               state_d = MPC_ST_IDLE;
               err_d   = 1'b1;
            end else if (needs_cas2) begin
               state_d = MPC_ST_CAS1; // R5
            end else begin
               state_d = MPC_ST_IDLE; // R8
            end
         end
         MPC_ST_CAS1: begin
            // Anything but a clean CAS-2 abandons the training command.
            if (cas2_first) begin // R5
               state_d = MPC_ST_CAS2;
            end else begin
               state_d = MPC_ST_IDLE;
               err_d   = 1'b1;
            end
         end
         MPC_ST_CAS2: begin
            state_d = MPC_ST_IDLE;
            if (link.cs || !link.cke || (link.ca != `MPC_CA_ZERO)) begin // R7
               err_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= MPC_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         op_top_q <= 1'b0;
      end else if (state_q == MPC_ST_IDLE && first_edge) begin
         op_top_q <= link.ca[`MPC_CA_TOP_BIT]; // R2
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pend_fn_q <= MPC_FN_NOP;
      end else if (state_q == MPC_ST_TRAIN2) begin
         pend_fn_q <= fn;
      end
   end

   // ------------------------------------------------------------
   // Function pulses
   // ------------------------------------------------------------
   logic train_done;
   logic cas_done;
   assign train_done = (state_q == MPC_ST_TRAIN2) && !link.cs && link.cke;
   assign cas_done   = (state_q == MPC_ST_CAS2) && !err_d;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         nop_q <= 1'b0;
      end else begin
         nop_q <= (state_q == MPC_ST_NOP2) && !err_d; // R4
      end
   end

   // Data-moving functions start on the CAS-2 second edge so that read
   // and write latency count from there, as for plain accesses.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         train_rd_q   <= 1'b0;
         pattern_rd_q <= 1'b0;
         train_wr_q   <= 1'b0;
      end else begin
         train_rd_q   <= cas_done && (pend_fn_q == MPC_FN_RD_BUF); // R6
         pattern_rd_q <= cas_done && (pend_fn_q == MPC_FN_PATTERN); // R6
         train_wr_q   <= cas_done && (pend_fn_q == MPC_FN_WR_BUF); // R6
      end
   end

   // The burst setting is not consulted for buffer bursts at all.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         train_bl_q <= `MPC_BL_RESET;
      end else if (cas_done && (pend_fn_q != MPC_FN_PATTERN)) begin
         train_bl_q <= `MPC_TRAIN_BL; // R13
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cal_start_q <= 1'b0;
         cal_latch_q <= 1'b0;
      end else begin
         cal_start_q <= train_done && (fn == MPC_FN_CAL_START); // R11
         cal_latch_q <= train_done && (fn == MPC_FN_CAL_LATCH); // R11
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         osc_run_q <= 1'b0;
      end else if (train_done && (fn == MPC_FN_OSC_START)) begin
         osc_run_q <= 1'b1; // R10
      end else if (train_done && (fn == MPC_FN_OSC_STOP)) begin
         osc_run_q <= 1'b0; // R10
      end
   end

   // ------------------------------------------------------------
   // Faults
   // ------------------------------------------------------------
   // Reserved and undefined codes execute nothing; they are only flagged.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reserved_code_q <= 1'b0;
         undef_code_q    <= 1'b0;
         seq_error_q     <= 1'b0;
      end else begin
         reserved_code_q <= train_done && (fn == MPC_FN_RESERVED);
         undef_code_q    <= train_done && (fn == MPC_FN_UNDEF);
         seq_error_q     <= err_d;
      end
   end

endmodule

//--- hdl/mpc_controller.sv
// Controller-side issuer of the multipurpose command and trailing CAS-2.
`timescale 1ns/1ps
module mpc_controller (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   // User request
   input  wire logic                  req,
   input  wire mpc_pkg::mpc_operand_t req_operand,
   output logic                       busy_q,
   output logic                       done_q,
   output logic                       refused_q,
   // Link to the DRAM
   mpc_if.ctrl                        link
);
   import mpc_pkg::*;
   `include "mpc_consts.svh"

   typedef enum logic [2:0] {
      MPC_CS_IDLE,
      MPC_CS_EDGE2,
      MPC_CS_CAS1,
      MPC_CS_CAS2
   } mpc_cstate_e;

   mpc_cstate_e  state_q;
   mpc_operand_t op_q;
   logic         cs_q;
   mpc_ca_t      ca_q;
   mpc_fn_e      fn;
   logic         needs_cas2;
   logic         take;

   mpc_operand_decode u_decode (
      .operand_field (op_q),
      .fn            (fn),
      .needs_cas2    (needs_cas2)
   );

   // Reserved codes are refused at the request port.
   assign take = req && (state_q == MPC_CS_IDLE) &&
                 (req_operand != `MPC_OP_RSV_A) && (req_operand != `MPC_OP_RSV_B); // R12

   assign link.cke = 1'b1; // R14
   assign link.cs  = cs_q;
   assign link.ca  = ca_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= MPC_CS_IDLE;
         op_q    <= 7'h00;
         cs_q    <= 1'b0;
         ca_q    <= 6'h00;
      end else begin
         cs_q <= 1'b0;
         ca_q <= `MPC_CA_ZERO;
         unique case (state_q)
            MPC_CS_IDLE: begin
               if (take) begin
                  op_q    <= req_operand;
                  cs_q    <= 1'b1; // R1
                  ca_q    <= {req_operand[`MPC_OP_TOP_BIT], `MPC_FIRST_LOW}; // R2
                  state_q <= MPC_CS_EDGE2;
               end
            end
            MPC_CS_EDGE2: begin
               ca_q    <= op_q[`MPC_CA_TOP_BIT:0]; // R2
               state_q <= needs_cas2 ? MPC_CS_CAS1 : MPC_CS_IDLE; // R8
            end
            MPC_CS_CAS1: begin
               cs_q    <= 1'b1; // R5
               ca_q    <= {1'b0, `MPC_CAS2_LOW}; // R7
               state_q <= MPC_CS_CAS2;
            end
            MPC_CS_CAS2: begin
               state_q <= MPC_CS_IDLE; // R7
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         busy_q    <= take || ((state_q != MPC_CS_IDLE) &&
                      !((state_q == MPC_CS_EDGE2) && !needs_cas2) &&
                      (state_q != MPC_CS_CAS2));
         done_q    <= ((state_q == MPC_CS_EDGE2) && !needs_cas2) ||
                      (state_q == MPC_CS_CAS2);
         refused_q <= req && (state_q == MPC_CS_IDLE) && !take;
      end
   end

endmodule

//--- testbench/mpc_link_checker.sv
// Wire checks on the command link between controller and decoder.
`timescale 1ns/1ps
module mpc_link_checker (
   // Clock and reset
   input wire logic             sys_clk,
   input wire logic             rstn,
   // Link signals
   input wire logic             cke,
   input wire logic             cs,
   input wire mpc_pkg::mpc_ca_t ca
);
   import mpc_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   sequence train_first;
      cs && ca == 6'h20;
   endsequence
   a_cke_across_cmd: assert property (cs |-> cke ##1 cke)
      else $error("clock enable dropped during a command");
   a_edge_pairing: assert property (cs |=> !cs)
      else $error("select held over two edges");
   a_first_code: assert property (cs |-> ca[4:0] inside {5'h00, 5'h12})
      else $error("unknown first-edge code");
   a_data_cas2: assert property (train_first ##1 (!cs && ca inside {6'h01, 6'h03, 6'h07})
      |=> cs && ca == 6'h12)
      else $error("data training not followed by CAS-2");
   a_cas2_ops_low: assert property (cs && ca[4:0] == 5'h12 |=> ca == 6'h00)
      else $error("CAS-2 operand not low");
   a_cas2_source: assert property (cs && ca[4:0] == 5'h12 |->
      $past(cs, 2) && $past(ca, 2) == 6'h20)
      else $error("CAS-2 without a training command before it");
   a_plain_no_cas2: assert property (train_first ##1
      (!cs && ca inside {6'h0B, 6'h0D, 6'h0F, 6'h11}) |=> !(cs && ca[4:0] == 5'h12))
      else $error("CAS-2 after a function that needs none");
   a_nop_no_cas2: assert property ((cs && ca == 6'h00) ##1 !cs |=>
      !(cs && ca[4:0] == 5'h12))
      else $error("CAS-2 after a no-operation");
   a_reserved_never: assert property (train_first |=> !(ca inside {6'h05, 6'h09}))
      else $error("reserved code on the link");
   c_osc_start: cover property (train_first ##1 ca == 6'h0B);
   c_cas2: cover property ((cs && ca == 6'h12) ##1 ca == 6'h00);
   c_nop: cover property ((cs && ca == 6'h00) ##1 !cs);
endmodule

//--- testbench/tb_top.sv
// Bench joining controller to decoder, plus a decoder driven by hand for faults.
`timescale 1ns/1ps
module tb_top;
   import mpc_pkg::*;
   logic         sys_clk;
   logic         rstn;
   logic         req;
   mpc_operand_t req_operand;
   logic         busy_q;
   logic         done_q;
   logic         refused_q;
   logic [8:0]   pa;
   logic [8:0]   pb;
   logic [10:0]  seen_a;
   logic [8:0]   seen_b;
   logic [4:0]   bl_a;
   logic         osc_a;
   logic         osc_b;
   int           errors;
   int           samples_checked;
   int           cycles;
   logic [6:0]   ops [9] = '{7'h00, 7'h3F, 7'h41, 7'h43, 7'h47, 7'h4F, 7'h51, 7'h45, 7'h49};
   logic [10:0]  exps [9] = '{11'h500, 11'h500, 11'h480, 11'h440, 11'h420, 11'h410, 11'h408,
                              11'h200, 11'h200};
   mpc_if la();
   mpc_if lb();
   // ---------------------------------------------
   // Instances
   // ---------------------------------------------
   mpc_controller i_mpc_controller (.sys_clk(sys_clk), .rstn(rstn), .req(req),
      .req_operand(req_operand), .busy_q(busy_q), .done_q(done_q), .refused_q(refused_q),
      .link(la));
   mpc_device i_mpc_device (.sys_clk(sys_clk), .rstn(rstn), .link(la), .nop_q(pa[8]),
      .train_rd_q(pa[7]), .pattern_rd_q(pa[6]), .train_wr_q(pa[5]), .cal_start_q(pa[4]),
      .cal_latch_q(pa[3]), .train_bl_q(bl_a), .osc_run_q(osc_a), .reserved_code_q(pa[2]),
      .undef_code_q(pa[1]), .seq_error_q(pa[0]));
   // The second decoder faces the bench, which breaks the controller's rules on purpose.
   mpc_device i_mpc_device_b (.sys_clk(sys_clk), .rstn(rstn), .link(lb), .nop_q(pb[8]),
      .train_rd_q(pb[7]), .pattern_rd_q(pb[6]), .train_wr_q(pb[5]), .cal_start_q(pb[4]),
      .cal_latch_q(pb[3]), .train_bl_q(), .osc_run_q(osc_b), .reserved_code_q(pb[2]),
      .undef_code_q(pb[1]), .seq_error_q(pb[0]));
   mpc_link_checker i_mpc_link_checker (.sys_clk(sys_clk), .rstn(rstn), .cke(la.cke),
      .cs(la.cs), .ca(la.ca));
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Pulses last one cycle, so they are gathered here rather than sampled once.
   always @(posedge sys_clk) begin
      seen_a <= seen_a | {done_q, refused_q, pa};
      seen_b <= seen_b | pb;
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic issue(input logic [6:0] op, input logic [10:0] exp);
      logic cas;
      cas = (op == 7'h41 || op == 7'h43 || op == 7'h47);
      @(negedge sys_clk);
      seen_a = '0;
      req = 1'b1;
      req_operand = op;
      @(negedge sys_clk);
      req = 1'b0;
      if (op == 7'h45 || op == 7'h49) begin
         chk("refused", {refused_q, la.cs}, 2'b10);
      end else begin
         chk("edge1", {busy_q, la.cs, la.cke, la.ca}, {3'b111, op[6], 5'h00});
         @(negedge sys_clk);
         chk("edge2", {done_q, la.cs, la.ca}, {~cas, 1'b0, op[5:0]});
         if (cas) begin
            @(negedge sys_clk);
            chk("cas2_first", {la.cs, la.ca}, 7'h52);
            @(negedge sys_clk);
            chk("cas2_second", {done_q, la.cs, la.ca}, 8'h80);
            // The data function must start in the cycle after the CAS-2 second edge.
            @(negedge sys_clk);
            chk("launch", pa[7:5], exp[7:5]);
         end
      end
      repeat (3) @(negedge sys_clk);
      chk("pulses", seen_a, exp);
   endtask
   task automatic b_edge(input logic c, input logic [5:0] a, input logic k);
      @(negedge sys_clk);
      lb.cs = c;
      lb.ca = a;
      lb.cke = k;
   endtask
   task automatic b_end(input string name, input logic [8:0] exp);
      // Idle lines carry a changing pattern so a stale value is never mistaken for data.
      repeat (3) begin
         @(negedge sys_clk);
         lb.cs = 1'b0;
         lb.ca = ~lb.ca;
         lb.cke = 1'b1;
      end
      chk(name, seen_b, exp);
      seen_b = '0;
   endtask
   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      rstn = 1'b0;
      req = 1'b0;
      req_operand = '0;
      lb.cs = 1'b0;
      lb.ca = '0;
      lb.cke = 1'b1;
      seen_a = '0;
      seen_b = '0;
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      chk("bl_reset", bl_a, 5'h00);
      issue(7'h4B, 11'h400);
      chk("osc_on", osc_a, 1'b1);
      issue(7'h4D, 11'h400);
      chk("osc_off", osc_a, 1'b0);
      for (int i = 0; i < 9; i++) issue(ops[i], exps[i]);
      chk("burst_len", bl_a, 5'h10);
      b_edge(1'b1, 6'h00, 1'b1);
      b_edge(1'b0, 6'h3F, 1'b1);
      b_end("nop_any", 9'h100);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h05, 1'b1);
      b_end("reserved", 9'h004);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h13, 1'b1);
      b_end("undefined", 9'h002);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h01, 1'b1);
      b_end("no_cas2", 9'h001);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h07, 1'b1);
      b_edge(1'b1, 6'h12, 1'b1);
      b_edge(1'b0, 6'h01, 1'b1);
      b_end("cas2_ops", 9'h001);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h0B, 1'b0);
      b_end("cke_low", 9'h001);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b1, 6'h0B, 1'b1);
      b_end("cs_twice", 9'h001);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h0B, 1'b1);
      b_edge(1'b1, 6'h20, 1'b1);
      b_edge(1'b0, 6'h0F, 1'b1);
      b_end("back_to_back", 9'h010);
      chk("osc_b_on", osc_b, 1'b1);
      conclude();
   end
endmodule
